// >>> core/ptm_core.sv
// periodic timer core with apb register slave and interrupt
// Operation
// [RL1] counter counts up, 16 bits in instance 0, 10 bits in instance 1
// [RL2] comparators A and P compare the counter with their stored values
// [RL3] overflow or selected compare match clears counter and raises a flag
// [RL4] software cannot write the counter; only an on rising edge clears it; code also clears it on overflow and selected compare match
// [RL5] on bit high runs counter; rising edge clears it; low holds value
// [RL6] in compare output mode on rising edge resets pin to initial level
// [RL7] pause freezes the counter; clearing pause resumes from held value
// [RL8] clock select picks sys/4, high, high/16, high/64, timebase, pin edges
// [RL9] code 101 on the 16-bit instance supplies no clock at all
// [RL10] counter readable as byte pair; compare values read/write byte pairs
// [RL11] 10-bit instance high bytes hold only bits 9 and 8
// [RL12] control A: pause bit 7, clock select 6..4, on bit 3, rest zero
// [RL13] control A resets to zero: off, running, clock code 000
// [RL14] mode field: compare output, capture, pwm/single pulse, timer
// [RL15] clear select 0: P match or overflow; 1: A match only; code also clears on overflow, and pwm mode ignores the bit
// [RL16] external pin edges are synchronised and counted one per edge
// [RL17] paused or off, clock enables are ignored: no counts or events
`timescale 1ns/1ps
`include "ptm_regs.svh"

module ptm_core #(
	parameter bit INST = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timebase_tick,
	input wire logic external_clock_pin,
	output logic timer_out,
	output logic timer_out_en,
	output logic irq
);
	import ptm_pkg::*;

	logic [7:0] timer_control_a;
	logic [7:0] timer_control_b;
	logic [15:0] counter;
	logic [15:0] compare_a_value;
	logic [15:0] compare_p_value;
	logic [`PTM_ST_W-1:0] status;
	logic [`PTM_ST_W-1:0] mask;
	logic [5:0] prescale;
	logic [2:0] pin_sync;
	logic on_prev;
	logic out_level;

	logic pause_bit;
	logic on_control_bit;
	ptm_clk_sel_t clock_select_field;
	ptm_mode_t mode_field;
	ptm_pin_action_t pin_action;
	logic output_control_bit;
	logic output_invert_bit;
	logic counter_clear_select;
	logic [15:0] cnt_max;
	logic [7:0] hi_mask;
	logic setup;
	logic wr_en;
	logic unmapped;
	logic src_tick;
	logic run;
	logic tick;
	logic on_rise;
	logic a_hit;
	logic p_hit;
	logic ovf;
	logic clr;
	logic p_flag;
	logic [`PTM_ST_W-1:0] events;
	logic [31:0] next_prdata;

	assign pause_bit = timer_control_a[`PTM_A_PAUSE];
	assign on_control_bit = timer_control_a[`PTM_A_ON];
	assign clock_select_field = ptm_clk_sel_t'(
		timer_control_a[`PTM_A_CKSEL_HI:`PTM_A_CKSEL_LO]);
	assign mode_field = ptm_mode_t'(
		timer_control_b[`PTM_B_MODE_HI:`PTM_B_MODE_LO]);
	assign pin_action = ptm_pin_action_t'(
		timer_control_b[`PTM_B_ACT_HI:`PTM_B_ACT_LO]);
	assign output_control_bit = timer_control_b[`PTM_B_OC];
	assign output_invert_bit = timer_control_b[`PTM_B_POL];
	assign counter_clear_select = timer_control_b[`PTM_B_CCLR];
	assign cnt_max = INST ? `PTM_MAX_10 : `PTM_MAX_16; // [RL1]
	assign hi_mask = INST ? `PTM_HI_MASK_10 : `PTM_HI_MASK_16; // [RL11]

	// apb: one wait-free access phase, pready raised from the setup cycle
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && pready;
	always_comb begin
		unmapped = 1'b0;
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			`PTM_OFS_CTRL_A: next_prdata[7:0] =
				timer_control_a & `PTM_CTRL_A_WMASK; // [RL12]
			`PTM_OFS_CTRL_B: next_prdata[7:0] = timer_control_b;
			`PTM_OFS_CNT_LO: next_prdata[7:0] = counter[7:0]; // [RL10]
			`PTM_OFS_CNT_HI: next_prdata[7:0] = counter[15:8] & hi_mask;
			`PTM_OFS_CMPA_LO: next_prdata[7:0] = compare_a_value[7:0];
			`PTM_OFS_CMPA_HI: next_prdata[7:0] =
				compare_a_value[15:8] & hi_mask; // [RL11]
			`PTM_OFS_CMPP_LO: next_prdata[7:0] = compare_p_value[7:0];
			`PTM_OFS_CMPP_HI: next_prdata[7:0] =
				compare_p_value[15:8] & hi_mask;
			`PTM_OFS_STATUS: next_prdata[`PTM_ST_W-1:0] = status;
			`PTM_OFS_MASK: next_prdata[`PTM_ST_W-1:0] = mask;
			default: unmapped = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup && unmapped;
			// read data sampled at setup; counter may move by the access edge
			if (setup && !pwrite) begin
				prdata <= unmapped ? 32'h0000_0000 : next_prdata;
			end
		end
	end

	// control and compare registers; counter has no write path [RL4]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_a <= `PTM_CTRL_A_RST; // [RL13]
			timer_control_b <= `PTM_CTRL_B_RST;
			compare_a_value <= `PTM_CNT_RST;
			compare_p_value <= `PTM_CNT_RST;
			mask <= `PTM_ST_RST;
		end else if (wr_en) begin
			unique case (paddr)
				`PTM_OFS_CTRL_A: timer_control_a <=
					pwdata[7:0] & `PTM_CTRL_A_WMASK; // [RL12]
				`PTM_OFS_CTRL_B: timer_control_b <= pwdata[7:0]; // [RL14]
				`PTM_OFS_CMPA_LO: compare_a_value[7:0] <= pwdata[7:0];
				`PTM_OFS_CMPA_HI: compare_a_value[15:8] <=
					pwdata[7:0] & hi_mask; // [RL11]
				`PTM_OFS_CMPP_LO: compare_p_value[7:0] <= pwdata[7:0];
				`PTM_OFS_CMPP_HI: compare_p_value[15:8] <=
					pwdata[7:0] & hi_mask;
				`PTM_OFS_MASK: mask <= pwdata[`PTM_ST_W-1:0];
				default: ;
			endcase
		end
	end

	// prescaler; high clock taken as pclk itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale <= 6'h00;
		end else begin
			prescale <= prescale + 6'h01;
		end
	end

	// pin_sync[0] feeds only pin_sync[1]; edges seen on [2:1] [RL16]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync <= 3'h0;
		end else begin
			pin_sync <= {pin_sync[1:0], external_clock_pin};
		end
	end

	always_comb begin
		unique case (clock_select_field) // [RL8]
			ptm_ck_sys4: src_tick =
				(prescale & `PTM_DIV_4) == `PTM_DIV_4;
			ptm_ck_high: src_tick = 1'b1;
			ptm_ck_high16: src_tick =
				(prescale & `PTM_DIV_16) == `PTM_DIV_16;
			ptm_ck_high64: src_tick = prescale == `PTM_DIV_64;
			ptm_ck_tbc: src_tick = timebase_tick;
			ptm_ck_undef: src_tick = INST; // [RL9]
			ptm_ck_pin_rise: src_tick = pin_sync[1] && !pin_sync[2]; // [RL16]
			ptm_ck_pin_fall: src_tick = !pin_sync[1] && pin_sync[2];
		endcase
	end

	assign run = on_control_bit && !pause_bit; // [RL7]
	assign tick = run && src_tick; // [RL17]
	assign on_rise = on_control_bit && !on_prev; // [RL5]
	// a zero compare value never matches; zero P lets the counter overflow
	assign a_hit = tick && (compare_a_value != `PTM_CNT_RST)
		&& (counter == compare_a_value); // [RL2]
	assign p_hit = tick && (compare_p_value != `PTM_CNT_RST)
		&& (counter == compare_p_value); // [RL2]
	assign ovf = tick && (counter == cnt_max);
	always_comb begin
		if (mode_field == ptm_mode_pwm) begin
			clr = ovf || p_hit;
		end else begin
			clr = ovf || (counter_clear_select ? a_hit : p_hit); // [RL15]
		end
	end
	assign p_flag = (mode_field == ptm_mode_pwm) || !counter_clear_select;
	assign events[`PTM_ST_A] = a_hit;
	assign events[`PTM_ST_P] = p_flag && (p_hit
		|| (ovf && compare_p_value == `PTM_CNT_RST)); // [RL15]
	assign events[`PTM_ST_OVF] = ovf;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_prev <= 1'b0;
		end else begin
			on_prev <= on_control_bit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter <= `PTM_CNT_RST;
		end else if (on_rise) begin
			counter <= `PTM_CNT_RST; // [RL5] [RL4]
		end else if (tick) begin
			counter <= clr ? `PTM_CNT_RST
				: ((counter + 16'h0001) & cnt_max); // [RL1] [RL3]
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= `PTM_ST_RST;
		end else if (wr_en && paddr == `PTM_OFS_STATUS) begin
			status <= (status & ~pwdata[`PTM_ST_W-1:0]) | events; // [RL3]
		end else begin
			status <= status | events; // [RL3]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// compare output level; single pulse treated like pwm output here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_level <= 1'b0;
		end else if (mode_field == ptm_mode_pwm) begin
			unique case (pin_action)
				ptm_act_none: out_level <= !output_control_bit;
				ptm_act_low: out_level <= output_control_bit;
				default: out_level <= (counter < compare_a_value)
					? output_control_bit : !output_control_bit;
			endcase
		end else if (on_rise) begin
			out_level <= output_control_bit; // [RL6]
		end else if (a_hit) begin
			unique case (pin_action)
				ptm_act_none: out_level <= out_level;
				ptm_act_low: out_level <= 1'b0;
				ptm_act_high: out_level <= 1'b1;
				ptm_act_toggle: out_level <= !out_level;
			endcase
		end
	end

	// pin is released in timer and capture modes so it can serve as plain io
	// pin level registered so it never glitches; one cycle behind out_level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_out <= 1'b0;
			timer_out_en <= 1'b0;
		end else begin
			timer_out <= out_level ^ output_invert_bit;
			timer_out_en <= (mode_field == ptm_mode_compare)
				|| (mode_field == ptm_mode_pwm); // [RL14]
		end
	end

	sequence s_setup_rd_a;
		psel && !penable && !pwrite && paddr == `PTM_OFS_CTRL_A;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence

	AST_CTRL_A_READ: assert property ( // [RL12]
		@(posedge pclk) disable iff (!presetn)
		s_setup_rd_a ##1 s_access |-> prdata[2:0] == 3'h0)
		else $error("control a low bits not zero");
	AST_ON_CLEARS: assert property ( // [RL5]
		@(posedge pclk) disable iff (!presetn)
		on_rise |=> counter == `PTM_CNT_RST)
		else $error("on rising edge did not clear counter");
	AST_HOLD_IDLE: assert property ( // [RL17]
		@(posedge pclk) disable iff (!presetn)
		(!run && !on_rise) |=> $stable(counter))
		else $error("counter moved while off or paused");
	AST_NO_EVENT_IDLE: assert property ( // [RL17]
		@(posedge pclk) disable iff (!presetn)
		!run |-> events == `PTM_ST_RST)
		else $error("event raised while off or paused");
	AST_INCREMENT: assert property ( // [RL1]
		@(posedge pclk) disable iff (!presetn)
		(tick && !clr && !on_rise) |=>
		counter == (($past(counter) + 16'h0001) & cnt_max))
		else $error("counter did not step by one");
	AST_OVF_CLEAR: assert property ( // [RL3]
		@(posedge pclk) disable iff (!presetn)
		(ovf && !on_rise) |=> counter == `PTM_CNT_RST
		&& status[`PTM_ST_OVF])
		else $error("overflow did not clear and flag");
	AST_A_CLEAR: assert property ( // [RL15]
		@(posedge pclk) disable iff (!presetn)
		(a_hit && counter_clear_select && mode_field != ptm_mode_pwm
		&& !on_rise) |=> counter == `PTM_CNT_RST
		&& status[`PTM_ST_A])
		else $error("comparator a match did not clear");
	AST_P_SILENT: assert property ( // [RL15]
		@(posedge pclk) disable iff (!presetn)
		(counter_clear_select && mode_field != ptm_mode_pwm)
		|-> !events[`PTM_ST_P])
		else $error("p flag raised with clear select high");
	AST_NO_CLOCK_101: assert property ( // [RL9]
		@(posedge pclk) disable iff (!presetn)
		(!INST && clock_select_field == ptm_ck_undef && !on_rise)
		|=> $stable(counter))
		else $error("undefined clock code still counts");
	AST_OUT_INIT: assert property ( // [RL6]
		@(posedge pclk) disable iff (!presetn)
		(on_rise && mode_field == ptm_mode_compare) ##1
		(mode_field == ptm_mode_compare) |->
		out_level == $past(output_control_bit))
		else $error("output not at initial level after on");
	AST_WIDTH_10: assert property ( // [RL11]
		@(posedge pclk) disable iff (!presetn)
		INST |-> counter[15:10] == 6'h00
		&& compare_a_value[15:10] == 6'h00)
		else $error("10-bit instance upper bits set");

endmodule // ptm_core

// >>> core/ptm_pkg.sv
// types shared by the periodic timer core
package ptm_pkg;
	typedef enum logic [1:0] {
		ptm_mode_compare,
		ptm_mode_capture,
		ptm_mode_pwm,
		ptm_mode_timer
	} ptm_mode_t;

	typedef enum logic [2:0] {
		ptm_ck_sys4,
		ptm_ck_high,
		ptm_ck_high16,
		ptm_ck_high64,
		ptm_ck_tbc,
		ptm_ck_undef,
		ptm_ck_pin_rise,
		ptm_ck_pin_fall
	} ptm_clk_sel_t;

	typedef enum logic [1:0] {
		ptm_act_none,
		ptm_act_low,
		ptm_act_high,
		ptm_act_toggle
	} ptm_pin_action_t;
endpackage

// >>> core/ptm_regs.svh
// register offsets, field positions, reset values and divider masks
`ifndef PTM_REGS_SVH
`define PTM_REGS_SVH

`define PTM_OFS_CTRL_A 8'h00
`define PTM_OFS_CTRL_B 8'h04
`define PTM_OFS_CNT_LO 8'h08
`define PTM_OFS_CNT_HI 8'h0c
`define PTM_OFS_CMPA_LO 8'h10
`define PTM_OFS_CMPA_HI 8'h14
`define PTM_OFS_CMPP_LO 8'h18
`define PTM_OFS_CMPP_HI 8'h1c
`define PTM_OFS_STATUS 8'h20
`define PTM_OFS_MASK 8'h24

`define PTM_A_PAUSE 7
`define PTM_A_CKSEL_HI 6
`define PTM_A_CKSEL_LO 4
`define PTM_A_ON 3
`define PTM_B_MODE_HI 7
`define PTM_B_MODE_LO 6
`define PTM_B_ACT_HI 5
`define PTM_B_ACT_LO 4
`define PTM_B_OC 3
`define PTM_B_POL 2
`define PTM_B_CAPTS 1
`define PTM_B_CCLR 0

`define PTM_ST_A 0
`define PTM_ST_P 1
`define PTM_ST_OVF 2
`define PTM_ST_W 3

`define PTM_CTRL_A_RST 8'h00
`define PTM_CTRL_A_WMASK 8'hf8
`define PTM_CTRL_B_RST 8'h00
`define PTM_CNT_RST 16'h0000
`define PTM_ST_RST 3'h0
`define PTM_MAX_16 16'hffff
`define PTM_MAX_10 16'h03ff
`define PTM_HI_MASK_16 8'hff
`define PTM_HI_MASK_10 8'h03

`define PTM_DIV_4 6'h03
`define PTM_DIV_16 6'h0f
`define PTM_DIV_64 6'h3f

`endif

// >>> testbench/testbench.sv
// self-checking bench for the 10-bit and 16-bit periodic timer core over apb
`timescale 1ns/1ps
`include "ptm_regs.svh"

module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] prdata16;
	logic [31:0] rd;
	logic [31:0] rd16;
	logic pready, pslverr, err, timer_out, timer_out_en, irq;
	logic tick = 1'b0;
	logic pin = 1'b0;
	logic [31:0] v;
	int num_errors = 0;
	int n_tests = 0;

	always #4 pclk = ~pclk;

	ptm_core #(.INST(1'b1)) i_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.timebase_tick(tick),
		.external_clock_pin(pin),
		.timer_out(timer_out),
		.timer_out_en(timer_out_en),
		.irq(irq)
	);

	// 16-bit twin on the same bus; only its read data is watched
	ptm_core #(.INST(1'b0)) i_dut16 (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata16),
		.pready(),
		.pslverr(),
		.timebase_tick(tick),
		.external_clock_pin(pin),
		.timer_out(),
		.timer_out_en(),
		.irq()
	);

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		rd16 = prdata16;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic in_rng(input logic [31:0] lo, input logic [31:0] hi);
		chk(32'(rd >= lo && rd <= hi), 32'h1);
	endtask

	task automatic t_regs;
		rdr(`PTM_OFS_CTRL_A);
		chk(rd, 32'h0);
		wr(`PTM_OFS_CTRL_A, 32'hf7);
		rdr(`PTM_OFS_CTRL_A);
		chk(rd, 32'hf0);
		wr(`PTM_OFS_CTRL_A, 32'h0);
		wr(`PTM_OFS_CMPA_HI, 32'hff);
		rdr(`PTM_OFS_CMPA_HI);
		chk(rd, 32'h3);
		chk(rd16, 32'hff);
		wr(`PTM_OFS_CMPA_HI, 32'h0);
		wr(`PTM_OFS_CMPP_LO, 32'ha5);
		rdr(`PTM_OFS_CMPP_LO);
		chk(rd, 32'ha5);
		wr(`PTM_OFS_CNT_LO, 32'h55);
		rdr(`PTM_OFS_CNT_LO);
		chk(rd, 32'h0);
		rdr(8'h28);
		chk({rd[31:1], err}, 32'h1);
	endtask

	task automatic t_period;
		wr(`PTM_OFS_CMPP_LO, 32'h3);
		wr(`PTM_OFS_MASK, 32'h2);
		wr(`PTM_OFS_CTRL_A, 32'h18);
		for (int i = 0; i < 40 && irq !== 1'b1; i++) @(negedge pclk);
		chk(32'(irq), 32'h1);
		for (int i = 0; i < 5; i++) begin
			rdr(`PTM_OFS_CNT_LO);
			in_rng(32'h0, 32'h3);
		end
		wr(`PTM_OFS_CTRL_A, 32'h0);
		rdr(`PTM_OFS_STATUS);
		chk(rd, 32'h2);
		wr(`PTM_OFS_MASK, 32'h0);
		repeat (2) @(negedge pclk);
		chk(32'(irq), 32'h0);
		wr(`PTM_OFS_STATUS, 32'h7);
		rdr(`PTM_OFS_STATUS);
		chk(rd, 32'h0);
		// clear on A only: no P flag although P is below A
		wr(`PTM_OFS_CTRL_B, 32'h1);
		wr(`PTM_OFS_CMPA_LO, 32'h5);
		wr(`PTM_OFS_CMPP_LO, 32'h2);
		wr(`PTM_OFS_CTRL_A, 32'h18);
		for (int i = 0; i < 4; i++) begin
			rdr(`PTM_OFS_CNT_LO);
			in_rng(32'h0, 32'h5);
		end
		wr(`PTM_OFS_CTRL_A, 32'h0);
		rdr(`PTM_OFS_STATUS);
		chk(rd, 32'h1);
		wr(`PTM_OFS_STATUS, 32'h7);
		wr(`PTM_OFS_CTRL_B, 32'h0);
		wr(`PTM_OFS_CMPA_LO, 32'h0);
		wr(`PTM_OFS_CMPP_LO, 32'h0);
	endtask

	task automatic t_ovf;
		wr(`PTM_OFS_CTRL_A, 32'h18);
		repeat (1030) @(posedge pclk);
		wr(`PTM_OFS_CTRL_A, 32'h0);
		rdr(`PTM_OFS_STATUS);
		chk(rd, 32'h6);
		rdr(`PTM_OFS_CNT_HI);
		in_rng(32'h0, 32'h3);
		wr(`PTM_OFS_STATUS, 32'h7);
	endtask

	task automatic t_pause;
		wr(`PTM_OFS_CTRL_A, 32'h08);
		repeat (40) @(posedge pclk);
		wr(`PTM_OFS_CTRL_A, 32'h88);
		rdr(`PTM_OFS_CNT_LO);
		v = rd;
		repeat (20) @(posedge pclk);
		rdr(`PTM_OFS_CNT_LO);
		chk(rd, v);
		wr(`PTM_OFS_CTRL_A, 32'h08);
		repeat (20) @(posedge pclk);
		rdr(`PTM_OFS_CNT_LO);
		in_rng(v + 32'h4, v + 32'h8);
		wr(`PTM_OFS_CTRL_A, 32'h0);
		rdr(`PTM_OFS_CNT_LO);
		v = rd;
		repeat (20) @(posedge pclk);
		rdr(`PTM_OFS_CNT_LO);
		chk(rd, v);
		wr(`PTM_OFS_CTRL_A, 32'h08);
		rdr(`PTM_OFS_CNT_LO);
		in_rng(32'h0, 32'h2);
		wr(`PTM_OFS_CTRL_A, 32'h0);
	endtask

	task automatic t_clk;
		int dv;
		// code 101 counts every cycle here, nothing on the 16-bit twin
		for (int c = 0; c < 6; c++) begin
			if (c != 4) begin
				dv = (c == 0) ? 4 : (c == 2) ? 16 : (c == 3) ? 64 : 1;
				wr(`PTM_OFS_CTRL_A, 32'({1'b0, c[2:0], 4'h8}));
				repeat (200) @(posedge pclk);
				rdr(`PTM_OFS_CNT_LO);
				in_rng(32'(200 / dv - 1), 32'(205 / dv + 1));
				if (c == 5) begin
					chk(rd16, 32'h0);
				end else begin
					chk(rd16, rd);
				end
				wr(`PTM_OFS_CTRL_A, 32'h0);
			end
		end
		// timebase ticks and pin edges are driven together each time
		for (int c = 4; c < 8; c++) begin
			if (c != 5) begin
				wr(`PTM_OFS_CTRL_A, 32'({1'b0, c[2:0], 4'h8}));
				for (int k = 0; k < 9; k++) begin
					@(posedge pclk);
					tick <= 1'b1;
					pin <= 1'b1;
					@(posedge pclk);
					tick <= 1'b0;
					repeat (3) @(posedge pclk);
					pin <= 1'b0;
					repeat (4) @(posedge pclk);
				end
				repeat (6) @(posedge pclk);
				rdr(`PTM_OFS_CNT_LO);
				chk(rd, 32'h9);
				wr(`PTM_OFS_CTRL_A, 32'h0);
			end
		end
	endtask

	task automatic t_pin;
		for (int m = 0; m < 4; m++) begin
			wr(`PTM_OFS_CTRL_B, 32'({m[1:0], 6'h0}));
			repeat (2) @(negedge pclk);
			chk(32'(timer_out_en), 32'(m[0] == 1'b0));
		end
		for (int oc = 0; oc < 2; oc++) begin
			wr(`PTM_OFS_CMPA_LO, 32'h3);
			wr(`PTM_OFS_CTRL_B, 32'({4'h3, oc[0], 3'h0}));
			wr(`PTM_OFS_CTRL_A, 32'h18);
			repeat (30) @(posedge pclk);
			wr(`PTM_OFS_CTRL_A, 32'h0);
			wr(`PTM_OFS_CMPA_LO, 32'hff);
			wr(`PTM_OFS_CTRL_A, 32'h18);
			repeat (3) @(negedge pclk);
			chk(32'({timer_out_en, timer_out}), 32'({1'b1, oc[0]}));
			wr(`PTM_OFS_CTRL_A, 32'h0);
		end
	endtask

	task automatic final_report;
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_period;
		t_ovf;
		t_pause;
		t_clk;
		t_pin;
		final_report;
	end

	// whole sequence needs well under ten thousand cycles
	initial begin
		repeat (30000) @(posedge pclk);
		num_errors++;
		final_report;
	end
endmodule // testbench
